/* parallel_io_channel_handshake_tb.sv */
// self-checking bench for the parallel channel control block
`timescale 1ns/100ps
module parallel_io_channel_handshake_tb;
  localparam int DW  = pio_pkg::DATA_W;
  localparam int TMO = 50;
  pio_pkg::pio_pin_in_t  pin_in;
  pio_pkg::pio_pin_out_t pin_out;
  logic [DW-1:0]         din, dout, in_word, out_wdata, fn_word;
  logic                  mclk, arst_n, link_mode, ie_support, peer_caps, in_start, intr_arm;
  logic                  in_wvalid, intr_wvalid, in_done, out_start, out_wvalid, out_wtake;
  logic                  out_done, fn_buf_active, fn_force, fn_done, scan_valid, ack_q, stb_q;
  logic                  link_halt, link_tmo;
  logic [15:0]           in_count, out_count;
  logic [15:0][8:0]      ev_req;
  logic [3:0]            scan_chan, scan_fn;
  logic [DW:0]           exp_q[$];
  int                    fail_count = 0, num_checks = 0, done_cnt = 0, seed = 73;
  int                    tmo_cnt = 0, halt_cyc = 0, take_cnt = 0;

  pio_chan #(.TMO_CYC(TMO)) pio_chan_i (.mclk(mclk), .arst_n(arst_n), .pin_in(pin_in),
    .din(din), .pin_out(pin_out), .dout(dout), .link_mode(link_mode),
    .ie_support(ie_support), .peer_caps(peer_caps), .in_start(in_start),
    .in_count(in_count), .intr_arm(intr_arm), .in_word(in_word), .in_wvalid(in_wvalid),
    .intr_wvalid(intr_wvalid), .in_done(in_done), .out_start(out_start),
    .out_count(out_count), .out_wdata(out_wdata), .out_wvalid(out_wvalid),
    .out_wtake(out_wtake), .out_done(out_done), .fn_buf_active(fn_buf_active),
    .fn_force(fn_force), .fn_word(fn_word), .fn_done(fn_done), .link_halt(link_halt),
    .link_tmo(link_tmo), .ev_req(ev_req), .scan_valid(scan_valid), .scan_chan(scan_chan),
    .scan_fn(scan_fn));
  pio_periph pio_periph_i (.mclk(mclk), .pin_in(pin_in), .din(din), .pin_out(pin_out),
    .dout(dout));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      fail_count++;
    end
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // expected scan result: highest channel, then lowest function index
  function automatic logic [8:0] scan_exp(input logic [15:0][8:0] ev);
    logic [8:0] r;
    r = '0;
    for (int c = 0; c < 16; c++)
      for (int f = 8; f >= 0; f--)
        if (ev[c][f]) r = {1'b1, 4'(c), 4'(f)};
    return r;
  endfunction

  // watcher: each captured or presented word takes the oldest note
  always @(posedge mclk) begin
    #1;
    if (in_wvalid === 1'b1 || intr_wvalid === 1'b1 ||
        (pin_out.out_ack === 1'b1 && !ack_q) || (pin_out.fn_strobe === 1'b1 && !stb_q)) begin
      if (exp_q.size() == 0) check("unexpected word", 0, 1);
      else if (in_wvalid === 1'b1 || intr_wvalid === 1'b1)
        check("input word", 32'(exp_q.pop_front()), {1'b0, intr_wvalid, in_word});
      else check("output word", 32'(exp_q.pop_front()), {2'b0, dout});
    end
    ack_q = pin_out.out_ack === 1'b1;
    stb_q = pin_out.fn_strobe === 1'b1;
    if (in_done === 1'b1 || out_done === 1'b1 || fn_done === 1'b1) done_cnt++;
    if (link_halt === 1'b1) halt_cyc++;
    if (link_tmo === 1'b1) tmo_cnt++;
    if (out_wtake === 1'b1) take_cnt++;
  end

  initial begin
    #(60000 * 10);
    fail_count++;
    finish_test;
  end

  initial begin
    logic [DW-1:0] w;
    int            dly, wid;
    bit            fell, ok;
    {arst_n, link_mode, ie_support, in_start, intr_arm, out_start, out_wvalid} = '0;
    {fn_buf_active, fn_force, ack_q, stb_q} = '0;
    peer_caps = 1'b1;
    {in_count, out_count, out_wdata, fn_word} = '0;
    ev_req = '0;
    repeat (20) @(posedge mclk);
    arst_n <= 1'b1;
    // input data: two counted words, then a third that must wait
    @(posedge mclk);
    in_count <= 16'h0002;
    in_start <= 1'b1;
    @(posedge mclk);
    in_start <= 1'b0;
    for (int k = 0; k < 3; k++) begin
      w = DW'($random(seed));
      if (k < 2) exp_q.push_back({1'b0, w});
      pio_periph_i.send_in(w, 1'b0, (k < 2) ? 2000 : 1200, dly, wid, fell);
      if (k < 2) check("input ack delay", 1, dly >= pio_pkg::IN_ACK_DLY_NS / 10);
      if (k < 2) check("input ack width", pio_pkg::IN_ACK_W_NS / 10, wid);
      if (k == 2) check("input refused", 1200, dly);
    end
    $display("test input done");
    // interrupts without then with the enable line
    for (int m = 0; m < 2; m++) begin
      @(posedge mclk);
      ie_support <= 1'(m);
      intr_arm   <= 1'(m);
      @(posedge mclk);
      intr_arm <= 1'b0;
      w = DW'($random(seed));
      exp_q.push_back({1'b1, w});
      pio_periph_i.send_in(w, 1'b1, 2000, dly, wid, fell);
      check("intr ack delay", 1, dly >= pio_pkg::INTR_DLY_NS / 10);
      check("intr ack width", pio_pkg::IN_ACK_W_NS / 10, wid);
      if (m == 1) check("enable drop with ack", 1, fell);
    end
    $display("test interrupt done");
    // output data: two counted words, then a request left unanswered
    @(posedge mclk);
    out_count  <= 16'h0002;
    out_start  <= 1'b1;
    out_wvalid <= 1'b1;
    @(posedge mclk);
    out_start <= 1'b0;
    for (int k = 0; k < 3; k++) begin
      w = DW'($random(seed));
      @(posedge mclk);
      out_wdata <= w;
      if (k < 2) exp_q.push_back({1'b0, w});
      pio_periph_i.take_out(1'b0, 1'b1, 1'b0, ok);
      check("output answered", k < 2, ok);
    end
    $display("test output done");
    // function words: inactive buffer, active buffer, forced
    for (int k = 0; k < 3; k++) begin
      w = DW'($random(seed));
      @(posedge mclk);
      fn_word       <= w;
      fn_buf_active <= k > 0;
      fn_force      <= k == 2;
      @(posedge mclk);
      fn_force <= 1'b0;
      if (k > 0) exp_q.push_back({1'b0, w});
      pio_periph_i.take_out(1'b1, k < 2, 1'b0, ok);
      check("function answered", k > 0, ok);
    end
    check("done pulses", 4, done_cnt);
    check("notes left", 0, exp_q.size());
    $display("test output and function done");
    // link: forced command against a low enable halts until time-out, then one Ready word
    w = DW'($random(seed));
    @(posedge mclk);
    link_mode <= 1'b1;
    peer_caps <= 1'b0;
    fn_word   <= w;
    fn_force  <= 1'b1;
    @(posedge mclk);
    fn_force <= 1'b0;
    exp_q.push_back({1'b0, w});
    pio_periph_i.take_out(1'b1, 1'b0, 1'b0, ok);
    check("forced link answered", 1, ok);
    w = DW'($random(seed));
    @(posedge mclk);
    out_count <= 16'h0001;
    out_start <= 1'b1;
    out_wdata <= w;
    @(posedge mclk);
    out_start <= 1'b0;
    exp_q.push_back({1'b0, w});
    pio_periph_i.take_out(1'b0, 1'b0, 1'b1, ok);
    check("link ready answered", 1, ok);
    check("halt cycles", TMO, halt_cyc);
    check("time-outs", 1, tmo_cnt);
    check("word takes", 3, take_cnt);
    check("link notes left", 0, exp_q.size());
    $display("test link done");
    // priority scan over random event flags
    for (int k = 0; k < 40; k++) begin
      @(posedge mclk);
      for (int c = 0; c < 16; c++)
        ev_req[c] <= (k % 8 == 0) ? 9'h000 : 9'($random(seed) & $random(seed) & $random(seed));
      @(posedge mclk);
      #1;
      check("scan", 32'(scan_exp(ev_req)), {scan_valid, scan_chan, scan_fn});
    end
    $display("test scan done");
    finish_test;
  end
endmodule

/* pio_chan.sv */
// one parallel i/o channel: input, output, function, interrupt and link handshakes
`timescale 1ns/100ps
module pio_chan #(
  parameter int WC_W    = 16,
  parameter int TMO_CYC = 100000
) (
  input  wire logic                                    mclk,
  input  wire logic                                    arst_n,
  input  wire pio_pkg::pio_pin_in_t                    pin_in,
  input  wire logic [pio_pkg::DATA_W-1:0]              din,
  output pio_pkg::pio_pin_out_t                        pin_out,
  output logic [pio_pkg::DATA_W-1:0]                   dout,
  input  wire logic                                    link_mode,
  input  wire logic                                    ie_support,
  input  wire logic                                    peer_caps,
  input  wire logic                                    in_start,
  input  wire logic [WC_W-1:0]                         in_count,
  input  wire logic                                    intr_arm,
  output logic [pio_pkg::DATA_W-1:0]                   in_word,
  output logic                                         in_wvalid,
  output logic                                         intr_wvalid,
  output logic                                         in_done,
  input  wire logic                                    out_start,
  input  wire logic [WC_W-1:0]                         out_count,
  input  wire logic [pio_pkg::DATA_W-1:0]              out_wdata,
  input  wire logic                                    out_wvalid,
  output logic                                         out_wtake,
  output logic                                         out_done,
  input  wire logic                                    fn_buf_active,
  input  wire logic                                    fn_force,
  input  wire logic [pio_pkg::DATA_W-1:0]              fn_word,
  output logic                                         fn_done,
  output logic                                         link_halt,
  output logic                                         link_tmo,
  input  wire logic [pio_pkg::NCHAN-1:0][pio_pkg::NFN-1:0] ev_req,
  output logic                                         scan_valid,
  output logic [pio_pkg::CHAN_W-1:0]                   scan_chan,
  output logic [pio_pkg::FN_W-1:0]                     scan_fn
);

  pio_pkg::pio_pin_in_t            pin_s1;
  pio_pkg::pio_pin_in_t            pin_s2;
  logic [pio_pkg::DATA_W-1:0]      din_s1;
  logic [pio_pkg::DATA_W-1:0]      din_s2;
  logic [pio_pkg::NLINE-1:0]       pin_v;
  logic [pio_pkg::CNT_W-1:0]       age [pio_pkg::NLINE];
  logic [pio_pkg::NLINE-1:0]       armed;
  logic [pio_pkg::NLINE-1:0]       take;
  pio_pkg::pio_in_st_t             ist;
  pio_pkg::pio_out_st_t            ost;
  logic [pio_pkg::CNT_W-1:0]       icnt;
  logic [pio_pkg::CNT_W-1:0]       ocnt;
  logic [pio_pkg::TMO_W-1:0]       tcnt;
  logic [WC_W-1:0]                 in_left;
  logic [WC_W-1:0]                 out_left;
  logic                            fn_pend;
  logic                            okind_fn;
  logic                            oforced;
  logic                            took_intr;
  logic                            next_sv;
  logic [pio_pkg::CHAN_W-1:0]      next_sc;
  logic [pio_pkg::FN_W-1:0]        next_sf;

  // two-stage synchronisers on every incoming level and on the data lines
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      din_s1 <= '0;
      din_s2 <= '0;
    end else begin
      pin_s1 <= pin_in;
      pin_s2 <= pin_s1;
      din_s1 <= din;
      din_s2 <= din_s1;
    end
  end

  assign pin_v = pin_s2;

  // per line: how long it has been high, and whether it was seen low since last take
  for (genvar i = 0; i < pio_pkg::NLINE; i++) begin : g_line
    always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
        age[i]   <= '0;
        armed[i] <= 1'b0;
      end else begin
        age[i]   <= !pin_v[i] ? '0 : ((&age[i]) ? age[i] : age[i] + 1'b1);
        armed[i] <= take[i] ? 1'b0 : (!pin_v[i] ? 1'b1 : armed[i]);
      end
    end
  end

  // input side decode: interrupt words outrank data words
  wire ie_used   = ie_support && (!link_mode || peer_caps);
  wire intr_ok   = pin_v[pio_pkg::L_INTR] && armed[pio_pkg::L_INTR]
                   && (pin_out.intr_en || !ie_used);
  wire take_intr = (ist == pio_pkg::IN_IDLE) && intr_ok
                   && (age[pio_pkg::L_INTR] >= pio_pkg::INTR_DLY_CYC);
  wire take_data = (ist == pio_pkg::IN_IDLE) && !take_intr && (in_left != '0)
                   && pin_v[pio_pkg::L_IREQ] && armed[pio_pkg::L_IREQ]
                   && (age[pio_pkg::L_IREQ] >= pio_pkg::IN_ACK_DLY_CYC);
  wire ack_end   = (icnt == pio_pkg::IN_ACK_W_CYC - 1'b1);

  // input acknowledge sequencer
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ist        <= pio_pkg::IN_IDLE;
      icnt       <= '0;
      took_intr  <= 1'b0;
    end else begin
      case (ist)
        pio_pkg::IN_IDLE: begin
          icnt <= '0;
          if (take_intr || take_data) begin
            ist       <= pio_pkg::IN_ACK;
            took_intr <= take_intr;
          end
        end
        pio_pkg::IN_ACK: begin
          icnt <= icnt + 1'b1;
          if (ack_end) begin
            ist <= pio_pkg::IN_IDLE;
          end
        end
        default: ist <= pio_pkg::IN_IDLE;
      endcase
    end
  end

  // input pins, word capture and word count
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pin_out.in_ack  <= 1'b0;
      pin_out.intr_en <= 1'b0;
      in_word         <= '0;
      in_wvalid       <= 1'b0;
      intr_wvalid     <= 1'b0;
      in_done         <= 1'b0;
      in_left         <= '0;
    end else begin
      in_wvalid   <= take_data;
      intr_wvalid <= take_intr;
      in_done     <= take_data && (in_left == WC_W'(1));
      if (take_intr || take_data) begin
        in_word <= din_s2;
      end
      if (in_start) begin
        in_left <= in_count;
      end else if (take_data) begin
        in_left <= in_left - 1'b1;
      end
      if (take_intr) begin
        pin_out.intr_en <= 1'b0;
      end else if (intr_arm && ie_used) begin
        pin_out.intr_en <= 1'b1;
      end
      if (take_intr || take_data) begin
        pin_out.in_ack <= 1'b1;
      end else if (ist == pio_pkg::IN_ACK && ack_end) begin
        pin_out.in_ack <= 1'b0;
      end
    end
  end

  // output side decode: forced function, requested function, then data word
  // link: request pin is Resume
  wire resume     = pin_v[pio_pkg::L_OREQ];
  wire lnk_ready  = armed[pio_pkg::L_OREQ] && !resume;
  wire o_idle     = (ost == pio_pkg::OS_IDLE);
  wire force_ok   = fn_pend && (!link_mode || lnk_ready);
  // on a link, a peer without request support takes only forced function words
  wire fn_allowed = !link_mode || (peer_caps && lnk_ready);
  // answered only with active function buffer
  wire fn_req_ok  = fn_buf_active && fn_allowed && pin_v[pio_pkg::L_FREQ]
                    && armed[pio_pkg::L_FREQ]
                    && (age[pio_pkg::L_FREQ] >= pio_pkg::OUT_REQ_DLY_CYC);
  wire req_ok     = pin_v[pio_pkg::L_OREQ] && armed[pio_pkg::L_OREQ]
                    && (age[pio_pkg::L_OREQ] >= pio_pkg::OUT_REQ_DLY_CYC);
  // link data needs no request, only a quiet Resume
  wire data_ok    = (out_left != '0) && out_wvalid && (link_mode ? lnk_ready : req_ok);
  wire go_force   = o_idle && force_ok;
  wire go_fn      = o_idle && !force_ok && fn_req_ok;
  wire go_data    = o_idle && !force_ok && !fn_req_ok && data_ok;
  wire go_out     = go_force || go_fn || go_data;
  wire tmo_hit    = (tcnt == pio_pkg::TMO_W'(TMO_CYC - 1));
  // Resume ends the strobe in link mode
  wire strobe_end = link_mode ? (resume || tmo_hit)
                              : (ocnt == pio_pkg::OUT_ACK_W_CYC - 1'b1);
  wire setup_end  = (ocnt == pio_pkg::OUT_SETUP_CYC - 1'b1);
  wire hold_end   = (ocnt == pio_pkg::OUT_HOLD_CYC - 1'b1);

  assign take[pio_pkg::L_IREQ] = take_data;
  assign take[pio_pkg::L_INTR] = take_intr;
  assign take[pio_pkg::L_FREQ] = go_fn;
  assign take[pio_pkg::L_OREQ] = go_data || (link_mode && go_out);

  // output sequencer: place word, settle, strobe, hold data after strobe drops
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ost  <= pio_pkg::OS_IDLE;
      ocnt <= '0;
      tcnt <= '0;
    end else begin
      tcnt <= (ost == pio_pkg::OS_STROBE && link_mode) ? tcnt + 1'b1 : '0;
      case (ost)
        pio_pkg::OS_IDLE: begin
          ocnt <= '0;
          if (go_out) begin
            ost <= pio_pkg::OS_SETUP;
          end
        end
        pio_pkg::OS_SETUP: begin
          ocnt <= setup_end ? '0 : ocnt + 1'b1;
          if (setup_end) begin
            ost <= pio_pkg::OS_STROBE;
          end
        end
        pio_pkg::OS_STROBE: begin
          ocnt <= strobe_end ? '0 : ocnt + 1'b1;
          if (strobe_end) begin
            ost <= pio_pkg::OS_HOLD;
          end
        end
        pio_pkg::OS_HOLD: begin
          ocnt <= ocnt + 1'b1;
          if (hold_end) begin
            ost <= pio_pkg::OS_IDLE;
          end
        end
        default: ost <= pio_pkg::OS_IDLE;
      endcase
    end
  end

  // output pins, word counts and status pulses
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pin_out.out_ack   <= 1'b0;
      pin_out.fn_strobe <= 1'b0;
      dout              <= '0;
      out_left          <= '0;
      okind_fn          <= 1'b0;
      oforced           <= 1'b0;
      fn_pend           <= 1'b0;
      out_wtake         <= 1'b0;
      out_done          <= 1'b0;
      fn_done           <= 1'b0;
      link_halt         <= 1'b0;
      link_tmo          <= 1'b0;
    end else begin
      out_wtake <= go_data;
      out_done  <= go_data && (out_left == WC_W'(1));
      fn_done   <= (ost == pio_pkg::OS_STROBE) && strobe_end && okind_fn;
      link_tmo  <= (ost == pio_pkg::OS_STROBE) && link_mode && tmo_hit && !resume;
      // forced words wait for no request, on a link only for a quiet Resume; a new force wins over the clear
      fn_pend   <= fn_force || (fn_pend && !go_force);
      // word on the lines before the strobe
      if (go_out) begin
        dout     <= go_data ? out_wdata : fn_word;
        okind_fn <= !go_data;
        oforced  <= go_force;
      end
      if (out_start) begin
        out_left <= out_count;
      end else if (go_data) begin
        out_left <= out_left - 1'b1;
      end
      if (ost == pio_pkg::OS_SETUP && setup_end) begin
        pin_out.out_ack   <= !okind_fn;
        pin_out.fn_strobe <= okind_fn;
        // on a link, a forced strobe against a low enable halts the group
        link_halt <= okind_fn && oforced && link_mode && !pin_v[pio_pkg::L_FREQ];
      end else if (ost == pio_pkg::OS_STROBE && strobe_end) begin
        pin_out.out_ack   <= 1'b0;
        pin_out.fn_strobe <= 1'b0;
        link_halt         <= 1'b0;
      end
    end
  end

  // higher channel index wins; then lowest function index
  always_comb begin
    next_sv = 1'b0;
    next_sc = '0;
    next_sf = '0;
    for (int c = 0; c < pio_pkg::NCHAN; c++) begin
      if (|ev_req[c]) begin
        next_sv = 1'b1;
        next_sc = pio_pkg::CHAN_W'(c);
      end
    end
    for (int f = pio_pkg::NFN - 1; f >= 0; f--) begin
      if (ev_req[next_sc][f]) begin
        next_sf = pio_pkg::FN_W'(f);
      end
    end
  end

  // scan result register
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      scan_valid <= 1'b0;
      scan_chan  <= '0;
      scan_fn    <= '0;
    end else begin
      scan_valid <= next_sv;
      scan_chan  <= next_sc;
      scan_fn    <= next_sf;
    end
  end

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  sequence s_ack_rise;
    $rose(pin_out.in_ack);
  endsequence

  chk_ack_delay_data: assert property (
    s_ack_rise and ##0 !took_intr |-> $past(age[pio_pkg::L_IREQ]) >= pio_pkg::IN_ACK_DLY_CYC)
    else $error("input acknowledge came too early");
  chk_ack_delay_intr: assert property (
    s_ack_rise and ##0 took_intr |-> $past(age[pio_pkg::L_INTR]) >= pio_pkg::INTR_DLY_CYC)
    else $error("interrupt acknowledge came too early");
  chk_ie_drop_ack: assert property (
    s_ack_rise and ##0 took_intr |-> !pin_out.intr_en)
    else $error("interrupt enable still high at acknowledge");
  chk_ack_width_gap: assert property (
    s_ack_rise |-> pin_out.in_ack [*8] ##1 !$rose(pin_out.in_ack))
    else $error("input acknowledge pulse too short");
  chk_data_setup_ack: assert property (
    $rose(pin_out.out_ack) |-> $stable(dout) && ($past(ost) == pio_pkg::OS_SETUP))
    else $error("output data not settled before acknowledge");
  chk_data_hold_out: assert property (
    $fell(pin_out.out_ack) |-> ($stable(dout)) [*8])
    else $error("output data changed right after acknowledge dropped");
  chk_count_limit: assert property (
    go_data |-> out_left != '0)
    else $error("output word sent beyond the count");
  chk_fn_buf_gate: assert property (
    go_fn |=> okind_fn && !oforced && ost == pio_pkg::OS_SETUP)
    else $error("requested function started wrongly");
  chk_halt_strobe: assert property (
    link_halt |-> pin_out.fn_strobe && link_mode)
    else $error("halt flag without a standing strobe");
  chk_link_resume: assert property (
    $fell(pin_out.out_ack) && link_mode |-> $past(resume) || $past(tmo_hit))
    else $error("Ready cleared without Resume or time-out");
  chk_scan_order: assert property (
    next_sv |=> scan_valid && |ev_req[scan_chan] || !$stable(ev_req))
    else $error("scan picked an idle channel");

endmodule

/* pio_periph.sv */
// peripheral model that answers one parallel channel
`timescale 1ns/100ps
module pio_periph (
  input  wire logic                       mclk,
  output pio_pkg::pio_pin_in_t            pin_in,
  output logic [pio_pkg::DATA_W-1:0]      din,
  input  wire pio_pkg::pio_pin_out_t      pin_out,
  input  wire logic [pio_pkg::DATA_W-1:0] dout
);
  initial begin
    pin_in = '0;
    din    = '0;
  end
  // send one input or interrupt word; reports wait, acknowledge width, enable drop
  // data placed first and held while the line is high
  task automatic send_in(input logic [pio_pkg::DATA_W-1:0] w, input bit intr, input int lim,
                         output int dly, output int wid, output bit fell);
    logic en_prev;
    dly = 0;
    @(posedge mclk);
    din <= w;
    @(posedge mclk);
    if (intr) pin_in.intr <= 1'b1;
    else pin_in.in_req <= 1'b1;
    do begin
      en_prev = pin_out.intr_en;
      @(posedge mclk);
      #1;
      dly++;
    end while (pin_out.in_ack !== 1'b1 && dly < lim);
    // enable falling with acknowledge marks an interrupt acknowledge
    fell = en_prev === 1'b1 && pin_out.intr_en === 1'b0;
    // release request and data once acknowledge is sensed; released data inverted
    @(posedge mclk);
    pin_in.in_req <= 1'b0;
    pin_in.intr   <= 1'b0;
    din           <= ~w;
    #1;
    wid = 1;
    while (pin_out.in_ack === 1'b1 && wid < 1000) begin
      @(posedge mclk);
      #1;
      wid++;
    end
    // rest low well past 0.53 us
    repeat (60) @(posedge mclk);
  endtask
  // wait for output acknowledge or strobe, with or without raising a request
  // request cleared once acknowledge or strobe is seen
  task automatic take_out(input bit fn, input bit req, input bit rsm, output bit ok);
    int n;
    n = 0;
    @(posedge mclk);
    if (req && fn) pin_in.fn_req <= 1'b1;
    else if (req) pin_in.out_req <= 1'b1;
    do begin
      @(posedge mclk);
      #1;
      n++;
    end while ((fn ? pin_out.fn_strobe : pin_out.out_ack) !== 1'b1 && n < 3000);
    ok = n < 3000;
    @(posedge mclk);
    pin_in.fn_req  <= 1'b0;
    // on a link the request pin answers Ready as Resume, then drops
    pin_in.out_req <= rsm;
    repeat (100) @(posedge mclk);
    pin_in.out_req <= 1'b0;
    repeat (300) @(posedge mclk);
  endtask
endmodule

/* pio_pkg.sv */
// shared constants, pin bundles and state types for the parallel channel
package pio_pkg;
  // clock and word sizes
  localparam int CLK_NS = 10;
  localparam int DATA_W = 30;
  localparam int CNT_W  = 10;
  localparam int TMO_W  = 24;
  localparam int NLINE  = 4;
  // priority scan shape: four groups of four channels, nine functions per channel
  localparam int NGROUP = 4;
  localparam int NCHAN  = 4 * NGROUP;
  localparam int CHAN_W = 4;
  localparam int NFN    = 9;
  localparam int FN_W   = 4;
  // bit positions of the incoming control lines inside pio_pin_in_t
  localparam int L_IREQ = 3;
  localparam int L_INTR = 2;
  localparam int L_OREQ = 1;
  localparam int L_FREQ = 0;
  // times in nanoseconds
  localparam int IN_ACK_DLY_NS  = 7750;
  localparam int INTR_DLY_NS    = 3750;
  localparam int IN_ACK_W_NS    = 2500;
  localparam int OUT_REQ_DLY_NS = 6750;
  localparam int OUT_SETUP_NS   = 400;
  localparam int OUT_ACK_W_NS   = 2200;
  localparam int OUT_HOLD_NS    = 500;
  // least times rounded up to whole cycles
  localparam logic [CNT_W-1:0] IN_ACK_DLY_CYC  = CNT_W'((IN_ACK_DLY_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] INTR_DLY_CYC    = CNT_W'((INTR_DLY_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] IN_ACK_W_CYC    = CNT_W'((IN_ACK_W_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] OUT_REQ_DLY_CYC = CNT_W'((OUT_REQ_DLY_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] OUT_SETUP_CYC   = CNT_W'((OUT_SETUP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] OUT_ACK_W_CYC   = CNT_W'((OUT_ACK_W_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] OUT_HOLD_CYC    = CNT_W'((OUT_HOLD_NS + CLK_NS - 1) / CLK_NS);
  // control lines from the far end
  typedef struct packed {
    logic in_req;
    logic intr;
    logic out_req;
    logic fn_req;
  } pio_pin_in_t;
  // control lines driven by this end
  typedef struct packed {
    logic intr_en;
    logic in_ack;
    logic out_ack;
    logic fn_strobe;
  } pio_pin_out_t;
  typedef enum logic {IN_IDLE, IN_ACK} pio_in_st_t;
  typedef enum logic [1:0] {OS_IDLE, OS_SETUP, OS_STROBE, OS_HOLD} pio_out_st_t;
endpackage
